// *** design/dsw_map.svh ***
// Register offsets, field positions, reset values and pattern constants
// for the data switch control block. Definitions only.
`ifndef DSW_MAP_SVH
`define DSW_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define DSW_TX_TIMING_OFS   16'h0018
`define DSW_RX_CONFIG_OFS   16'h0019
`define DSW_RX_TIMING_OFS   16'h001a

// ****************************************************************
// Reset values
// ****************************************************************
`define DSW_TX_TIMING_RST   16'h0c20
`define DSW_RX_CONFIG_RST   16'h2500
`define DSW_RX_TIMING_RST   16'h4c20

// ****************************************************************
// Field positions
// ****************************************************************
`define DSW_SRC_SEL_HI      15
`define DSW_SRC_SEL_LO      14
`define DSW_TRIG_MODE_HI    13
`define DSW_TRIG_MODE_LO    12
`define DSW_MASK_HI         7
`define DSW_MASK_LO         0
`define DSW_PIN_EN_BIT      12
`define DSW_PIN_HIGH_HI     11
`define DSW_PIN_HIGH_LO     10
`define DSW_PIN_LOW_HI      9
`define DSW_PIN_LOW_LO      8
`define DSW_OFF_SEL_BIT     7
`define DSW_ON_SEL_BIT      6
`define DSW_FILL_SEL_BIT    5

// ****************************************************************
// Patterns
// ****************************************************************
`define DSW_KR_FAULT        32'h0100_009c
`define DSW_KR_IDLE         32'h0707_0707
`define DSW_KX_COMMA        8'hbc
`define DSW_KX_I1_DATA      8'hc5
`define DSW_KX_I2_DATA      8'h50
`define DSW_KX_ERROR        8'hfe
`define DSW_STRAP_ROUTE_RX  1'b1

`endif

// *** design/dsw_pkg.sv ***
// Types shared by the data switch control block.
// Assumes dsw_map.svh sits beside it for the numeric constants.
package dsw_pkg;

  typedef enum logic [1:0] {
    DSW_MODE_KR,
    DSW_MODE_KX,
    DSW_MODE_OTHER
  } dsw_mode_type;

  typedef enum logic [1:0] {
    DSW_RUN,
    DSW_WAIT_OFF,
    DSW_MASK,
    DSW_WAIT_ON
  } dsw_state_type;

endpackage

// *** design/dsw_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module dsw_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign wr_ready_out = (count_q != (AW+1)'(DEPTH));
  assign rd_valid_out = (count_q != '0);
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_valid_out && rd_ready_in;
  assign rd_data_out  = mem_q[rd_ptr_q];

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= wr_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= bump(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= bump(rd_ptr_q);
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// *** design/dsw_switch_ctrl.sv ***
// Transmit and receive data switch control with its management registers.
// Assumes register accesses arrive already decoded from the management
// interface, and a strap pin asynchronous to ref_clk_in.
`timescale 1ns/100ps
`include "dsw_map.svh"
module dsw_switch_ctrl
  import dsw_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire logic [1:0]        link_mode_in,
  // Management register access
  input  wire logic [15:0]       mgmt_addr_in,
  input  wire logic              mgmt_wr_in,
  input  wire logic              mgmt_rd_in,
  input  wire logic [15:0]       mgmt_wdata_in,
  output logic      [15:0]       mgmt_rdata_out,
  output logic                   mgmt_rvalid_out,
  // Strap pin and settings held elsewhere
  input  wire logic              switch_strap_pin_in,
  input  wire logic              strap_switch_enable_in,
  input  wire logic              strap_switch_route_in,
  input  wire logic              tx_pin_control_enable_in,
  input  wire logic [1:0]        tx_pin_high_source_in,
  input  wire logic [1:0]        tx_pin_low_source_in,
  input  wire logic              tx_off_pattern_select_in,
  input  wire logic              tx_on_pattern_select_in,
  input  wire logic              tx_fill_select_in,
  input  wire logic [15:0]       tx_off_character_in,
  input  wire logic [15:0]       tx_on_character_in,
  input  wire logic [15:0]       rx_off_character_in,
  input  wire logic [15:0]       rx_on_character_in,
  // Transmit switch data
  input  wire logic [DATA_W-1:0] tx_low_speed_side_in,
  input  wire logic [DATA_W-1:0] tx_high_speed_side_in,
  input  wire logic              tx_valid_in,
  output logic                   tx_ready_out,
  output logic      [DATA_W-1:0] tx_data_out,
  output logic                   tx_valid_out,
  input  wire logic              tx_ready_in,
  output logic                   tx_source_out,
  output logic                   tx_pending_out,
  // Receive switch data
  input  wire logic [DATA_W-1:0] rx_low_speed_side_in,
  input  wire logic [DATA_W-1:0] rx_high_speed_side_in,
  input  wire logic              rx_valid_in,
  output logic                   rx_ready_out,
  output logic      [DATA_W-1:0] rx_data_out,
  output logic                   rx_valid_out,
  input  wire logic              rx_ready_in,
  output logic                   rx_source_out,
  output logic                   rx_pending_out
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [15:0] tx_timing_q;
  logic [15:0] rx_config_q;
  logic [15:0] rx_timing_q;
  logic [15:0] rdata_q;
  logic        rvalid_q;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      tx_timing_q <= `DSW_TX_TIMING_RST;
      rx_config_q <= `DSW_RX_CONFIG_RST;
      rx_timing_q <= `DSW_RX_TIMING_RST;
    end else if (mgmt_wr_in) begin
      // Reserved bits stay writable; software keeps them at default
      case (mgmt_addr_in)
        `DSW_TX_TIMING_OFS: tx_timing_q <= mgmt_wdata_in;
        `DSW_RX_CONFIG_OFS: rx_config_q <= mgmt_wdata_in;
        `DSW_RX_TIMING_OFS: rx_timing_q <= mgmt_wdata_in;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= mgmt_rd_in;
      if (mgmt_rd_in) begin
        case (mgmt_addr_in)
          `DSW_TX_TIMING_OFS: rdata_q <= tx_timing_q;
          `DSW_RX_CONFIG_OFS: rdata_q <= rx_config_q;
          `DSW_RX_TIMING_OFS: rdata_q <= rx_timing_q;
          default:            rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  assign mgmt_rdata_out  = rdata_q;
  assign mgmt_rvalid_out = rvalid_q;

  // ****************************************************************
  // Strap synchroniser
  // ****************************************************************
  logic strap_meta_q;
  logic strap_q;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      strap_meta_q <= 1'b0;
      strap_q      <= 1'b0;
    end else begin
      strap_meta_q <= switch_strap_pin_in;
      strap_q      <= strap_meta_q;
    end
  end

  // ****************************************************************
  // Source request per switch
  // ****************************************************************
  logic       tx_pin_active;
  logic       rx_pin_active;
  logic [1:0] want_src [2];

  // Pin control only counts once the strap is enabled and routed here
  assign tx_pin_active = tx_pin_control_enable_in && strap_switch_enable_in
                      && (strap_switch_route_in != `DSW_STRAP_ROUTE_RX);
  assign rx_pin_active = rx_config_q[`DSW_PIN_EN_BIT]
                      && strap_switch_enable_in
                      && (strap_switch_route_in == `DSW_STRAP_ROUTE_RX);

  assign want_src[0] = !tx_pin_active
      ? tx_timing_q[`DSW_SRC_SEL_HI:`DSW_SRC_SEL_LO]
      : (strap_q ? tx_pin_high_source_in : tx_pin_low_source_in);
  assign want_src[1] = !rx_pin_active
      ? rx_timing_q[`DSW_SRC_SEL_HI:`DSW_SRC_SEL_LO]
      : strap_q ? rx_config_q[`DSW_PIN_HIGH_HI:`DSW_PIN_HIGH_LO]
                : rx_config_q[`DSW_PIN_LOW_HI:`DSW_PIN_LOW_LO];

  // ****************************************************************
  // Pattern helpers
  // ****************************************************************
  function automatic logic is_kx_idle(input logic [DATA_W-1:0] w);
    is_kx_idle = (w[7:0] == `DSW_KX_COMMA)
              && ((w[15:8] == `DSW_KX_I1_DATA)
               || (w[15:8] == `DSW_KX_I2_DATA));
  endfunction

  // Trigger match for OFF or ON, by pattern select
  function automatic logic pattern_hit(input logic [DATA_W-1:0] w,
                                       input dsw_mode_type      md,
                                       input logic              sel,
                                       input logic [15:0]       chr);
    case (md)
      DSW_MODE_KR: pattern_hit = sel ? (w == DATA_W'(`DSW_KR_FAULT))
                                     : (w == DATA_W'(`DSW_KR_IDLE));
      DSW_MODE_KX: pattern_hit = sel ? (w[15:0] == chr) : is_kx_idle(w);
      // Outside KR and KX the selects mean nothing; never block
      default:     pattern_hit = 1'b1;
    endcase
  endfunction

  function automatic logic [DATA_W-1:0] fill_word(input dsw_mode_type md,
                                                  input logic sel);
    case (md)
      DSW_MODE_KX: fill_word = sel ? DATA_W'(`DSW_KX_ERROR)
                     : DATA_W'({`DSW_KX_I2_DATA, `DSW_KX_COMMA});
      DSW_MODE_KR: fill_word = sel ? DATA_W'(`DSW_KR_FAULT)
                                   : DATA_W'(`DSW_KR_IDLE);
      default:     fill_word = DATA_W'(`DSW_KR_IDLE);
    endcase
  endfunction

  // OFF accepts any data for 01, and for 10 on the receive side only
  function automatic logic off_any(input logic [1:0] tm, input logic is_rx);
    off_any = (tm == 2'b01) || (is_rx && (tm == 2'b10));
  endfunction

  // ****************************************************************
  // Per-switch data path
  // ****************************************************************
  dsw_mode_type      mode;
  logic [DATA_W-1:0] ls_data [2];
  logic [DATA_W-1:0] hs_data [2];
  logic              in_valid [2];
  logic              fifo_ready [2];
  logic [DATA_W-1:0] fifo_out [2];
  logic              fifo_valid [2];
  logic              out_ready [2];
  logic [15:0]       timing [2];
  logic              off_sel [2];
  logic              on_sel [2];
  logic              fill_sel [2];
  logic [15:0]       off_chr [2];
  logic [15:0]       on_chr [2];
  logic              cur_src [2];
  logic              pending [2];

  assign mode = (link_mode_in == 2'b00) ? DSW_MODE_KR
              : (link_mode_in == 2'b01) ? DSW_MODE_KX : DSW_MODE_OTHER;

  assign ls_data    = '{tx_low_speed_side_in, rx_low_speed_side_in};
  assign hs_data    = '{tx_high_speed_side_in, rx_high_speed_side_in};
  assign in_valid   = '{tx_valid_in, rx_valid_in};
  assign out_ready  = '{tx_ready_in, rx_ready_in};
  assign timing     = '{tx_timing_q, rx_timing_q};
  assign off_sel    = '{tx_off_pattern_select_in,
                        rx_config_q[`DSW_OFF_SEL_BIT]};
  assign on_sel     = '{tx_on_pattern_select_in,
                        rx_config_q[`DSW_ON_SEL_BIT]};
  assign fill_sel   = '{tx_fill_select_in,
                        rx_config_q[`DSW_FILL_SEL_BIT]};
  assign off_chr    = '{tx_off_character_in, rx_off_character_in};
  assign on_chr     = '{tx_on_character_in, rx_on_character_in};

  for (genvar i = 0; i < 2; i++) begin : g_sw
    dsw_state_type     state_q;
    logic              src_q;
    logic [7:0]        cnt_q;
    logic [DATA_W-1:0] live;
    logic [DATA_W-1:0] push_data;
    logic              step;
    logic              target;
    logic              change;
    logic [1:0]        tmode;
    logic              off_ok;
    logic              on_ok;

    assign tmode  = timing[i][`DSW_TRIG_MODE_HI:`DSW_TRIG_MODE_LO];
    assign live   = src_q ? hs_data[i] : ls_data[i];
    assign step   = in_valid[i] && fifo_ready[i];
    // Reserved source codes leave the switch where it is
    assign target = want_src[i][1] ? src_q : want_src[i][0];
    assign change = (target != src_q);
    assign off_ok = off_any(tmode, i == 1)
                 || pattern_hit(live, mode, off_sel[i], off_chr[i]);
    assign on_ok  = tmode[1]
                 || pattern_hit(live, mode, on_sel[i], on_chr[i]);

    always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
        state_q <= DSW_RUN;
        src_q   <= (i == 1);
        cnt_q   <= 8'h00;
      end else if (step) begin
        case (state_q)
          DSW_RUN: begin
            if (change) begin
              state_q <= DSW_WAIT_OFF;
            end
          end
          DSW_WAIT_OFF: begin
            if (!change) begin
              state_q <= DSW_RUN;
            end else if (off_ok) begin
              src_q   <= target;
              cnt_q   <= timing[i][`DSW_MASK_HI:`DSW_MASK_LO];
              state_q <= DSW_MASK;
            end
          end
          DSW_MASK: begin
            if (cnt_q <= 8'h01) begin
              state_q <= DSW_WAIT_ON;
            end else begin
              cnt_q <= cnt_q - 8'h01;
            end
          end
          DSW_WAIT_ON: begin
            if (on_ok) begin
              state_q <= DSW_RUN;
            end
          end
          default: state_q <= DSW_RUN;
        endcase
      end
    end

    // Stuffing covers the mask count and the wait for the ON trigger
    assign push_data = ((state_q == DSW_MASK) || (state_q == DSW_WAIT_ON))
                     ? fill_word(mode, fill_sel[i]) : live;

    assign cur_src[i] = src_q;
    assign pending[i] = (state_q != DSW_RUN);

    dsw_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
    ) u_fifo (
      .ref_clk_in   (ref_clk_in),
      .rst_in       (rst_in),
      .wr_data_in   (push_data),
      .wr_valid_in  (in_valid[i]),
      .wr_ready_out (fifo_ready[i]),
      .rd_data_out  (fifo_out[i]),
      .rd_valid_out (fifo_valid[i]),
      .rd_ready_in  (out_ready[i])
    );
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign tx_ready_out   = fifo_ready[0];
  assign tx_data_out    = fifo_out[0];
  assign tx_valid_out   = fifo_valid[0];
  assign tx_source_out  = cur_src[0];
  assign tx_pending_out = pending[0];
  assign rx_ready_out   = fifo_ready[1];
  assign rx_data_out    = fifo_out[1];
  assign rx_valid_out   = fifo_valid[1];
  assign rx_source_out  = cur_src[1];
  assign rx_pending_out = pending[1];

endmodule

// *** sim/dsw_switch_ctrl_asserts.sv ***
// Port-level checks for the data switch control block.
// Assumes a bind onto dsw_switch_ctrl, one clock, synchronous reset.
`timescale 1ns/100ps
module dsw_switch_ctrl_asserts #(
  parameter int DATA_W = 32
) (
  input wire logic              ref_clk_in,
  input wire logic              rst_in,
  input wire logic [15:0]       mgmt_addr_in,
  input wire logic              mgmt_wr_in,
  input wire logic              mgmt_rd_in,
  input wire logic [15:0]       mgmt_wdata_in,
  input wire logic [15:0]       mgmt_rdata_out,
  input wire logic              mgmt_rvalid_out,
  input wire logic [DATA_W-1:0] tx_data_out,
  input wire logic              tx_valid_out,
  input wire logic              tx_ready_in,
  input wire logic              tx_source_out,
  input wire logic              tx_pending_out,
  input wire logic              rx_valid_out,
  input wire logic              rx_ready_out,
  input wire logic              rx_source_out,
  input wire logic              rx_pending_out
);
  logic mapped;
  assign mapped = mgmt_addr_in inside {16'h0018, 16'h0019, 16'h001a};
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  // ****************************************************************
  // Register access
  // ****************************************************************
  sequence s_wr_gap_rd;
    mgmt_wr_in && mapped ##1 !mgmt_wr_in && !mgmt_rd_in
      ##1 mgmt_rd_in && !mgmt_wr_in && mgmt_addr_in == $past(mgmt_addr_in, 2);
  endsequence
  a_read_answered: assert property (mgmt_rd_in |=> mgmt_rvalid_out)
    else $error("read without answer");
  a_answer_has_read: assert property (mgmt_rvalid_out |-> $past(mgmt_rd_in))
    else $error("answer without read");
  a_unmapped_reads_zero: assert property (mgmt_rd_in && !mapped |=>
    mgmt_rdata_out == 16'h0000) else $error("unmapped read not zero");
  a_rdata_holds: assert property (!mgmt_rvalid_out |-> $stable(mgmt_rdata_out))
    else $error("read data moved");
  a_write_reads_back: assert property (
    s_wr_gap_rd |=> mgmt_rdata_out == $past(mgmt_wdata_in, 3))
    else $error("register did not read back");
  // ****************************************************************
  // Switch streams
  // ****************************************************************
  a_tx_switch_pending: assert property (
    $changed(tx_source_out) |-> tx_pending_out)
    else $error("tx source moved outside a switch");
  a_rx_switch_pending: assert property (
    $changed(rx_source_out) |-> rx_pending_out)
    else $error("rx source moved outside a switch");
  a_tx_out_held: assert property (tx_valid_out && !tx_ready_in |=>
    tx_valid_out && $stable(tx_data_out)) else $error("tx word dropped");
  a_rx_full_refuses: assert property (!rx_ready_out |->
    rx_valid_out && $past(rx_valid_out, 3)) else $error("rx refused early");
endmodule

// *** sim/dsw_mgmt_station.sv ***
// Management station model: one register write or read at a time.
// Assumes a shared clock and a read answer one cycle after the strobe.
`timescale 1ns/100ps
module dsw_mgmt_station (
  input  wire logic        ref_clk_in,
  input  wire logic [15:0] rdata_in,
  input  wire logic        rvalid_in,
  output logic      [15:0] addr_out,
  output logic             wr_out,
  output logic             rd_out,
  output logic      [15:0] wdata_out
);
  initial begin
    addr_out = 16'h0000;
    wdata_out = 16'h0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  task automatic write(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    #1;
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(posedge ref_clk_in);
    #1;
    wr_out = 1'b0;
    // Released data must not look still valid
    wdata_out = ~d;
  endtask
  task automatic read(input logic [15:0] a, output logic [15:0] d);
    @(posedge ref_clk_in);
    #1;
    addr_out = a;
    rd_out = 1'b1;
    @(posedge ref_clk_in);
    #1;
    rd_out = 1'b0;
    d = rvalid_in ? rdata_in : ~rdata_in;
  endtask
endmodule

// *** sim/tx_rx_data_switch_control_tb.sv ***
// Random self-checking bench with a queue model of both switches.
// Assumes the design files, checker and station model compile first.
`timescale 1ns/100ps
module tx_rx_data_switch_control_tb;
  logic        clk, rst, wr, rd, rvld, strap, sen, route, tpe;
  logic [1:0]  mode, thi, tlo, vin, rin, rdy, vo, srco, pend;
  logic [2:0]  tsel;
  logic [15:0] addr, wdat, rdat, got, r18, r19, r1a, chr [4];
  logic [31:0] lo [2], hi [2], dout [2], q [2][$];
  logic        src [2];
  int          st [2], cnt [2], seed, bad_count, comparisons, ph, k;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  dsw_switch_ctrl dut (
    .ref_clk_in(clk), .rst_in(rst), .link_mode_in(mode),
    .mgmt_addr_in(addr), .mgmt_wr_in(wr), .mgmt_rd_in(rd),
    .mgmt_wdata_in(wdat), .mgmt_rdata_out(rdat), .mgmt_rvalid_out(rvld),
    .switch_strap_pin_in(strap), .strap_switch_enable_in(sen),
    .strap_switch_route_in(route), .tx_pin_control_enable_in(tpe),
    .tx_pin_high_source_in(thi), .tx_pin_low_source_in(tlo),
    .tx_off_pattern_select_in(tsel[2]), .tx_on_pattern_select_in(tsel[1]),
    .tx_fill_select_in(tsel[0]), .tx_off_character_in(chr[0]),
    .tx_on_character_in(chr[1]), .rx_off_character_in(chr[2]),
    .rx_on_character_in(chr[3]), .tx_low_speed_side_in(lo[0]),
    .tx_high_speed_side_in(hi[0]), .tx_valid_in(vin[0]),
    .tx_ready_out(rdy[0]), .tx_data_out(dout[0]), .tx_valid_out(vo[0]),
    .tx_ready_in(rin[0]), .tx_source_out(srco[0]), .tx_pending_out(pend[0]),
    .rx_low_speed_side_in(lo[1]), .rx_high_speed_side_in(hi[1]),
    .rx_valid_in(vin[1]), .rx_ready_out(rdy[1]), .rx_data_out(dout[1]),
    .rx_valid_out(vo[1]), .rx_ready_in(rin[1]), .rx_source_out(srco[1]),
    .rx_pending_out(pend[1])
  );
  dsw_mgmt_station stn (
    .ref_clk_in(clk), .rdata_in(rdat), .rvalid_in(rvld), .addr_out(addr),
    .wr_out(wr), .rd_out(rd), .wdata_out(wdat)
  );
  // ****************************************************************
  // Checking and model
  // ****************************************************************
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [15:0] e);
    stn.read(a, got);
    check({16'h0000, got}, {16'h0000, e});
  endtask
  task automatic wrchk(input logic [15:0] a, input logic [15:0] d);
    stn.write(a, d);
    rdchk(a, d);
  endtask
  task automatic complete_run();
    $display("Counts: %0d compared, %0d bad", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function automatic logic hit(logic s, logic [31:0] w, logic [15:0] c);
    if (mode == 2'd0) return s ? w == 32'h0100_009c : w == 32'h0707_0707;
    if (mode == 2'd1) return s ? w[15:0] == c :
      w[7:0] == 8'hbc && (w[15:8] == 8'hc5 || w[15:8] == 8'h50);
    return 1'b1;
  endfunction
  function automatic logic [31:0] fill(logic s);
    if (mode == 2'd1) return s ? 32'h0000_00fe : 32'h0000_50bc;
    return s && mode == 2'd0 ? 32'h0100_009c : 32'h0707_0707;
  endfunction
  function automatic logic [31:0] word();
    case (2'($random(seed)))
      2'd0: return $random(seed);
      2'd1: return 32'h0707_0707;
      2'd2: return 32'h0100_009c;
      default: return 32'h0000_50bc;
    endcase
  endfunction
  task automatic step(input int s);
    logic [1:0]  c;
    logic [1:0]  m;
    logic [2:0]  sl;
    logic [31:0] w;
    c = s ? (r19[12] && sen && route ? (strap ? r19[11:10] : r19[9:8]) :
      r1a[15:14]) : (tpe && sen && !route ? (strap ? thi : tlo) :
      r18[15:14]);
    m = s ? r1a[13:12] : r18[13:12];
    sl = s ? r19[7:5] : tsel;
    w = src[s] ? hi[s] : lo[s];
    case (st[s])
      0: begin
        q[s].push_back(w);
        if (!c[1] && c[0] != src[s]) st[s] = 1;
      end
      1: begin
        q[s].push_back(w);
        if (m == 2'd1 || (s == 1 && m == 2'd2) ||
            hit(sl[2], w, chr[2*s])) begin
          src[s] = ~src[s];
          cnt[s] = 32'(s ? r1a[7:0] : r18[7:0]);
          if (cnt[s] == 0) cnt[s] = 1;
          st[s] = 2;
        end
      end
      2: begin
        q[s].push_back(fill(sl[0]));
        cnt[s]--;
        if (cnt[s] == 0) st[s] = 3;
      end
      default: begin
        q[s].push_back(fill(sl[0]));
        if (m[1] || hit(sl[1], w, chr[2*s+1])) st[s] = 0;
      end
    endcase
  endtask
  always @(posedge clk) begin
    if (rst) begin
      st = '{0, 0};
      src = '{1'b0, 1'b1};
      q[0].delete();
      q[1].delete();
    end else begin
      for (int s = 0; s < 2; s++) begin
        check(32'(srco[s]), 32'(src[s]));
        check(32'(pend[s]), 32'(st[s] != 0));
        check(32'(vo[s]), 32'(q[s].size() != 0));
        check(32'(rdy[s]), 32'(q[s].size() < 4));
        if (vo[s] && rin[s]) check(dout[s], q[s].pop_front());
        if (vin[s] && rdy[s]) step(s);
      end
    end
  end
  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    seed = 93932;
    rst = 1'b1;
    {mode, strap, sen, route, tpe, thi, tlo, tsel, vin, rin} = '0;
    lo = '{32'h0000_0000, 32'h0000_0000};
    hi = lo;
    chr = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    {r18, r19, r1a} = {16'h0c20, 16'h2500, 16'h4c20};
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    rdchk(16'h0018, 16'h0c20);
    rdchk(16'h0019, 16'h2500);
    rdchk(16'h001a, 16'h4c20);
    stn.write(16'h001b, 16'h1234);
    rdchk(16'h001b, 16'h0000);
    $display("Test reset values done");
    for (ph = 0; ph < 40; ph++) begin
      @(posedge clk);
      #1;
      vin = 2'b00;
      mode = 2'($random(seed));
      {strap, sen, route, tpe, thi, tlo, tsel} = 11'($random(seed));
      for (k = 0; k < 4; k++) begin
        chr[k] = $random(seed) & 1 ? 16'h50bc : 16'h009c;
      end
      r18 = {4'($random(seed)), 4'hc, 8'($random(seed)) & 8'h27};
      r19 = {3'b001, 8'($random(seed)), 5'h00};
      r1a = {4'($random(seed)), 4'hc, 8'($random(seed)) & 8'h27};
      wrchk(16'h0018, r18);
      wrchk(16'h0019, r19);
      wrchk(16'h001a, r1a);
      k = 0;
      // Runs at least 80 cycles and on until both switches settle, capped at 600 with the cap flagged as an error
      while ((k < 80 || pend != 2'b00) && k < 600) begin
        @(posedge clk);
        #1;
        vin = 2'($random(seed));
        rin = 2'($random(seed));
        for (int s = 0; s < 2; s++) begin
          lo[s] = word();
          hi[s] = word();
        end
        k++;
      end
      if (k >= 600) check(32'(pend), 32'h0000_0000);
      $display("Test phase %0d done", ph);
    end
    complete_run();
  end
  initial begin
    // 40 phases of at most about 620 cycles each
    #(50 * 30000);
    bad_count++;
    complete_run();
  end
endmodule
bind dsw_switch_ctrl dsw_switch_ctrl_asserts #(.DATA_W(DATA_W)) chk (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .mgmt_addr_in(mgmt_addr_in),
  .mgmt_wr_in(mgmt_wr_in), .mgmt_rd_in(mgmt_rd_in),
  .mgmt_wdata_in(mgmt_wdata_in), .mgmt_rdata_out(mgmt_rdata_out),
  .mgmt_rvalid_out(mgmt_rvalid_out), .tx_data_out(tx_data_out),
  .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in),
  .tx_source_out(tx_source_out), .tx_pending_out(tx_pending_out),
  .rx_valid_out(rx_valid_out), .rx_ready_out(rx_ready_out),
  .rx_source_out(rx_source_out), .rx_pending_out(rx_pending_out)
);
